// ---- inc/bcr_pkg.sv ----
// bcr_pkg: constants and types shared by the boot clock/reset defaults block.
// assumes a single core clock derived from the internal rc oscillator.
`default_nettype none
package bcr_pkg;
  // ==========================================================================
  // sizes and defaults
  localparam int          BCR_NUM_PLL       = 2;
  localparam int          BCR_NUM_MOD       = 8;
  localparam int          BCR_DIV_W         = 4;
  localparam int          BCR_SYNC_STAGES   = 2;
  localparam logic [31:0] BCR_RESET_ADDR    = 32'h8000_0000;
  localparam logic [3:0]  BCR_DIV_BYPASS    = 4'h0;
  localparam logic        BCR_PLL_OFF       = 1'b0;
  localparam logic        BCR_GATE_OPEN     = 1'b1;
  localparam logic [1:0]  BCR_SRC_RC        = 2'h0;
  localparam logic [1:0]  BCR_SRC_PLL0      = 2'h1;
  localparam logic [1:0]  BCR_SRC_PLL1      = 2'h2;

  // ==========================================================================
  // configuration written by boot code
  typedef struct packed {
    logic [1:0]                       clk_src;
    logic [BCR_NUM_PLL-1:0]           pll_en;
    logic [BCR_NUM_MOD-1:0]           mod_gate;
    logic [BCR_NUM_MOD*BCR_DIV_W-1:0] mod_div;
  } bcr_cfg_type;

  typedef enum logic [1:0] {
    BCR_ST_POWER_WAIT,
    BCR_ST_SYNC,
    BCR_ST_RUN
  } bcr_state_type;
endpackage
`default_nettype wire

// ---- verilog/bcr_boot_seq.sv ----
// bcr_boot_seq: holds the system in reset until power is stable, then
// releases it with default clock settings and a fixed fetch address.
// assumes power_ok_i is synchronous to core_clk_i (the rc oscillator clock).
//
// Operation
// - hold system reset while power unstable
// - default clock source is rc oscillator
// - all plls disabled at start-up
// - all module clock gates open at start-up
// - all dividers bypassed at start-up
// - fetch starts at fixed flash reset address
// - boot code may change plls, dividers, gates
`default_nettype none
module bcr_boot_seq
  import bcr_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        clk_en_i,
  input  wire logic        power_ok_i,
  input  wire logic        cfg_we_i,
  input  wire bcr_cfg_type cfg_i,
  output var  logic        sys_resetn_o,
  output var  logic        fetch_start_o,
  output var  logic [31:0] fetch_addr_o,
  output var  bcr_cfg_type cfg_o
);

  // ==========================================================================
  // defaults
  function automatic bcr_cfg_type default_cfg();
    bcr_cfg_type c;
    c.clk_src  = BCR_SRC_RC;
    c.pll_en   = {BCR_NUM_PLL{BCR_PLL_OFF}};
    c.mod_gate = {BCR_NUM_MOD{BCR_GATE_OPEN}};
    c.mod_div  = {BCR_NUM_MOD{BCR_DIV_BYPASS}};
    return c;
  endfunction

  // ==========================================================================
  // sequencer state and registered outputs
  //
  // three groups of state, each with its own next-value logic:
  //   power qualification - sequencer state and the stable-power filter
  //   reset and fetch     - system reset and the fetch launch pulse
  //   clock configuration - source, plls, module gates and dividers
  // the groups share their decode through the functions below, so any
  // change to when reset is released moves all three groups together.
  bcr_state_type              state;
  bcr_state_type              next_state;
  logic [BCR_SYNC_STAGES-1:0] sync;
  logic [BCR_SYNC_STAGES-1:0] next_sync;
  logic                       next_sys_resetn;
  logic                       next_fetch_start;
  logic [31:0]                next_fetch_addr;
  bcr_cfg_type                next_cfg;

  // ==========================================================================
  // shared decode

  // the filter is full once power has been good for every stage
  function automatic logic filter_full(
    input logic [BCR_SYNC_STAGES-1:0] stages
  );
    return stages[BCR_SYNC_STAGES-1];
  endfunction

  // release falls on the edge that leaves the filter with power still good
  function automatic logic release_due(
    input bcr_state_type              st,
    input logic [BCR_SYNC_STAGES-1:0] stages,
    input logic                       pwr_ok
  );
    return (st == BCR_ST_SYNC) && pwr_ok && filter_full(stages);
  endfunction

  // power lost while the system runs: reset drops on that same edge
  function automatic logic power_lost(
    input bcr_state_type st,
    input logic          pwr_ok
  );
    return (st == BCR_ST_RUN) && !pwr_ok;
  endfunction

  // boot code may only write once the system is out of reset; a write
  // during the filter is refused, and cfg_o keeps the defaults
  function automatic logic cfg_write_ok(
    input bcr_state_type st,
    input logic          pwr_ok,
    input logic          we
  );
    return (st == BCR_ST_RUN) && pwr_ok && we;
  endfunction

  // ==========================================================================
  // power qualification

  // a short count of stable cycles filters a glitchy power_ok; the cost
  // is a fixed release latency of the filter length plus two edges
  always_comb begin
    next_state = state;
    next_sync  = sync;
    case (state)
      BCR_ST_POWER_WAIT: begin
        next_sync = '0;
        if (power_ok_i) begin
          next_state = BCR_ST_SYNC;
        end
      end
      BCR_ST_SYNC: begin
        next_sync = {sync[BCR_SYNC_STAGES-2:0], 1'b1};
        if (!power_ok_i) begin
          next_state = BCR_ST_POWER_WAIT;
        end else if (release_due(state, sync, power_ok_i)) begin
          next_state = BCR_ST_RUN;
        end
      end
      BCR_ST_RUN: begin
        if (power_lost(state, power_ok_i)) begin
          next_state = BCR_ST_POWER_WAIT;
        end
      end
      default: begin
        next_state = BCR_ST_POWER_WAIT;
        next_sync  = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state <= BCR_ST_POWER_WAIT;
      sync  <= '0;
    end else if (clk_en_i) begin
      state <= next_state;
      sync  <= next_sync;
    end
  end

  // ==========================================================================
  // reset and fetch

  // reset is only ever released from the filter state, so a power dip of
  // any length restarts the whole filter before the core may run again
  always_comb begin
    next_sys_resetn  = sys_resetn_o;
    next_fetch_start = 1'b0;
    next_fetch_addr  = fetch_addr_o;
    case (state)
      BCR_ST_POWER_WAIT: begin
        next_sys_resetn = 1'b0;
      end
      BCR_ST_SYNC: begin
        if (release_due(state, sync, power_ok_i)) begin
          next_sys_resetn  = 1'b1;
          next_fetch_start = 1'b1;
          next_fetch_addr  = BCR_RESET_ADDR;
        end
      end
      BCR_ST_RUN: begin
        if (power_lost(state, power_ok_i)) begin
          next_sys_resetn = 1'b0;
        end
      end
      default: begin
        next_sys_resetn = 1'b0;
      end
    endcase
  end

  // the fetch address never moves; it is registered so that the core
  // sees it settled in the same cycle as the launch pulse
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sys_resetn_o  <= 1'b0;
      fetch_start_o <= 1'b0;
      fetch_addr_o  <= BCR_RESET_ADDR;
    end else if (clk_en_i) begin
      sys_resetn_o  <= next_sys_resetn;
      fetch_start_o <= next_fetch_start;
      fetch_addr_o  <= next_fetch_addr;
    end
  end

  // ==========================================================================
  // clock configuration

  // defaults are forced for as long as reset is held, so boot code always
  // starts from the same clock tree whatever ran before a power loss
  always_comb begin
    next_cfg = cfg_o;
    case (state)
      BCR_ST_POWER_WAIT: begin
        next_cfg = default_cfg();
      end
      BCR_ST_SYNC: begin
        next_cfg = cfg_o;
      end
      BCR_ST_RUN: begin
        if (power_lost(state, power_ok_i)) begin
          next_cfg = default_cfg();
        end else if (cfg_write_ok(state, power_ok_i, cfg_we_i)) begin
          next_cfg = cfg_i;
        end
      end
      default: begin
        next_cfg = default_cfg();
      end
    endcase
  end

  // writes carry no acknowledge; a refused write leaves no trace
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cfg_o <= default_cfg();
    end else if (clk_en_i) begin
      cfg_o <= next_cfg;
    end
  end

endmodule
`default_nettype wire

// ---- dv/bcr_boot_seq_assertions.sv ----
// checker on the boot sequencer ports
// assumes it is bound into the sequencer and sees only its ports
`default_nettype none
module bcr_sva
  import bcr_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic        clk_en_i,
  input wire logic        power_ok_i,
  input wire logic        cfg_we_i,
  input wire bcr_cfg_type cfg_i,
  input wire logic        sys_resetn_o,
  input wire logic        fetch_start_o,
  input wire logic [31:0] fetch_addr_o,
  input wire bcr_cfg_type cfg_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // ====
  // reset, fetch, config
  property p_h; clk_en_i && !power_ok_i |=> !sys_resetn_o; endproperty
  a_h: assert property (p_h) else $error("reset not held");
  property p_r; $rose(sys_resetn_o) |-> $past(power_ok_i, 4); endproperty
  a_r: assert property (p_r) else $error("early release");
  property p_f; $rose(sys_resetn_o) |-> fetch_start_o
    && fetch_addr_o == 32'h8000_0000; endproperty
  a_f: assert property (p_f) else $error("bad fetch");
  property p_d; !sys_resetn_o [*2] |-> cfg_o.clk_src == 2'h0;
  endproperty
  a_d: assert property (p_d) else $error("bad source");
  property p_l; !sys_resetn_o [*2] |-> cfg_o.pll_en == '0;
  endproperty
  a_l: assert property (p_l) else $error("pll on");
  property p_g; !sys_resetn_o [*2] |-> cfg_o.mod_gate == '1;
  endproperty
  a_g: assert property (p_g) else $error("gate shut");
  property p_v; !sys_resetn_o [*2] |-> cfg_o.mod_div == '0;
  endproperty
  a_v: assert property (p_v) else $error("divider on");
  property p_w; clk_en_i && sys_resetn_o && power_ok_i && cfg_we_i
    |=> cfg_o == $past(cfg_i); endproperty
  a_w: assert property (p_w) else $error("write lost");
  property p_p; clk_en_i && fetch_start_o |=> !fetch_start_o; endproperty
  a_p: assert property (p_p) else $error("long fetch pulse");
  property p_z; !clk_en_i |=> $stable(sys_resetn_o) && $stable(cfg_o)
    && $stable(fetch_start_o); endproperty
  a_z: assert property (p_z) else $error("frozen state moved");
endmodule
bind bcr_boot_seq bcr_sva u_sva (.*);
`default_nettype wire

// ---- dv/bcr_core_model.sv ----
// processor side: takes the first fetch address
// assumes the sequencer clock
`default_nettype none
module bcr_core_model (
  input  wire logic        clk_i,
  input  wire logic        fetch_start_i,
  input  wire logic [31:0] fetch_addr_i,
  output logic             booted_o,
  output logic [31:0]      boot_addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  always_ff @(posedge clk_i) begin
    booted_o <= fetch_start_i;
    if (fetch_start_i) boot_addr_o <= fetch_addr_i;
  end
endmodule
`default_nettype wire

// ---- dv/bcr_boot_seq_test.sv ----
// bench: power cycles, refused and accepted config writes
// assumes one 125 MHz clock
`default_nettype none
module bcr_boot_seq_test
  import bcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        c = 0, rn = 0, en = 1, pw = 0, we = 0, sr, fs, bt;
  bcr_cfg_type ci = '0, pc = '0, co;
  logic [31:0] fa, ba, q[$];
  int          n_errors = 0, tests_run = 0, i, n;
  // defaults: rc source, plls off, all gates open, no division
  localparam logic [47:0] DEF_CFG = 48'h00ff00000000;
  always #4 c = ~c;
  bcr_boot_seq DUT (.core_clk_i(c), .resetn_i(rn), .clk_en_i(en),
    .power_ok_i(pw), .cfg_we_i(we), .cfg_i(ci), .sys_resetn_o(sr),
    .fetch_start_o(fs), .fetch_addr_o(fa), .cfg_o(co));
  bcr_core_model core (.clk_i(c), .fetch_start_i(fs), .fetch_addr_i(fa),
    .booted_o(bt), .boot_addr_o(ba));
  task chk(input logic [47:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %h %h", $time, g, e);
    end
  endtask
  task results;
    chk(48'(q.size()), 48'h0);
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // power good to reset seen high: filter length plus entry, launch and sample
  task boot_wait;
    for (i = 0; i < 20 && sr !== 1'b1; i++) @(posedge c);
    chk(48'(i), 48'(BCR_SYNC_STAGES + 3));
  endtask
  // ====
  // refused write earlier must leave defaults
  always @(posedge c) if (bt === 1'b1) begin
    chk({16'h0, ba}, {16'h0, q.pop_front()});
    chk({4'h0, co}, DEF_CFG);
  end
  initial begin
    #9000 n_errors++;
    results();
  end
  initial begin
    void'($urandom(50245));
    repeat (2) @(posedge c);
    rn <= 1;
    for (n = 0; n < 6; n++) begin
      ci <= $bits(ci)'({$urandom, $urandom});
      we <= 1;
      @(posedge c) we <= 0;
      q.push_back(32'h8000_0000);
      pw <= 1;
      boot_wait();
      repeat (3) @(posedge c);
      ci <= $bits(ci)'({$urandom, $urandom});
      we <= 1;
      @(posedge c) we <= 0;
      @(posedge c) chk({4'h0, co}, {4'h0, ci});
      // a write while frozen must not land
      pc = ci;
      en <= 0;
      ci <= $bits(ci)'({$urandom, $urandom});
      we <= 1;
      @(posedge c) we <= 0;
      @(posedge c) en <= 1;
      @(posedge c) chk({4'h0, co}, {4'h0, pc});
      if (n % 2) begin
        // reset in mid-run with power good: a fresh boot follows
        rn <= 0;
        repeat (2) @(posedge c);
        chk({47'h0, sr}, 48'h0);
        chk({4'h0, co}, DEF_CFG);
        rn <= 1;
        q.push_back(32'h8000_0000);
        boot_wait();
        repeat (2) @(posedge c);
      end
      pw <= 0;
      repeat (3) @(posedge c);
      chk({47'h0, sr}, 48'h0);
      chk({4'h0, co}, DEF_CFG);
    end
    results();
  end
endmodule
`default_nettype wire
